/* hdl/snp_packetizer.sv */
`timescale 1ns/10ps
// Function
// - Serial bytes are collected in a store, not forwarded one at a time.
// - Store is released as one packet after an idle gap of the interval.
// - Interval zero releases received data at once, no idle wait.
// - Interval counts 10 ms units; fast-forward times the gap from the last byte.
// - Fast-forward skips the coalescing hold-off before a packet drains.
// - A configured separator sequence in the stream ends the packet.
// - Separator length is settable from zero to four bytes.
// - On a match, send at once, after one or after two more bytes.
// - With remote control on, report local line changes and apply peer lines.
module snp_packetizer #(
  parameter int unsigned UNIT_CYC = snp_pkg::FRAME_UNIT_CYC,
  parameter int unsigned DEPTH    = 32
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  ser_data,
  input  wire logic        ser_valid,
  output logic             ser_ready,
  output logic [7:0]       net_data,
  output logic             net_last,
  output logic             net_valid,
  input  wire logic        net_ready,
  input  wire logic [1:0]  local_lines,
  output logic             line_report_valid,
  output logic [1:0]       line_report,
  input  wire logic        peer_lines_valid,
  input  wire logic [1:0]  peer_lines,
  output logic [1:0]       applied_lines
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(UNIT_CYC + 1);
  localparam int HW = $clog2(snp_pkg::HOLDOFF_CYC + 1);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    snp_pkg::snp_fsm_t     st;
    logic [CW-1:0]         cnt;
    logic [CW-1:0]         rd;
    logic                  ff;
    logic                  rpc;
    logic [1:0]            lines_sw;
    logic [15:0]           interval;
    logic [2:0]            sep_len;
    logic [1:0]            sep_op;
    logic [31:0]           sep_bytes;
    logic [2:0]            match;
    logic [1:0]            tail;
    logic                  tail_on;
    logic [PW-1:0]         pre;
    logic [15:0]           units;
    logic [HW-1:0]         hold;
    logic                  ser_ready;
    logic                  hready;
    logic                  hresp;
    logic [31:0]           hrdata;
    logic                  a_sel;
    logic                  a_wr;
    logic [7:0]            a_addr;
    logic [1:0]            seen;
    logic                  rep_valid;
    logic [1:0]            rep;
    logic [1:0]            applied;
  } snp_state_t;

  snp_state_t    s_r;
  snp_state_t    s_nxt;
  logic          acc;
  logic          flush;
  logic          tick;
  logic          last;
  logic [2:0]    m;
  logic [8:0]    net_word;

  // Buffer handshake toward the network, declared ahead of the framer that reads it
  snp_buf_if #(.W(9)) bf ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Separator byte by position, first byte in the low lane
  function automatic logic [7:0] snp_sep_byte(input logic [31:0] b, input logic [1:0] i);
    return b[8*i +: 8];
  endfunction : snp_sep_byte

  // Register read mux
  function automatic logic [31:0] snp_read(input snp_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      snp_pkg::REG_CTRL: begin
        r[snp_pkg::CTRL_FF_POS]            = s.ff;
        r[snp_pkg::CTRL_RPC_POS]           = s.rpc;
        r[snp_pkg::CTRL_LINES_LSB +: 2]    = s.lines_sw;
      end
      snp_pkg::REG_INTERVAL:  r[15:0] = s.interval;
      snp_pkg::REG_SEP_CFG: begin
        r[snp_pkg::SEP_LEN_LSB +: 3]       = s.sep_len;
        r[snp_pkg::SEP_OP_LSB +: 2]        = s.sep_op;
      end
      snp_pkg::REG_SEP_BYTES: r = s.sep_bytes;
      snp_pkg::REG_STATUS: begin
        r[snp_pkg::STAT_CNT_LSB +: 8]      = 8'(s.cnt);
        r[snp_pkg::STAT_DRAIN_POS]         = (s.st == snp_pkg::ST_DRAIN);
        r[snp_pkg::STAT_HOLD_POS]          = (s.st == snp_pkg::ST_HOLD);
        r[snp_pkg::STAT_LOCAL_LSB +: 2]    = s.seen;
        r[snp_pkg::STAT_PEER_LSB +: 2]     = s.applied;
        r[snp_pkg::STAT_MATCH_LSB +: 3]    = s.match;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : snp_read

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    acc   = ser_valid & s_r.ser_ready;
    flush = 1'b0;
    tick  = 1'b0;
    m     = 3'h0;
    last  = (s_r.rd == s_r.cnt - 1'b1);

    // Register write in the data phase
    if (s_r.a_sel && s_r.a_wr) begin
      case (s_r.a_addr)
        snp_pkg::REG_CTRL: begin
          s_nxt.ff       = hwdata[snp_pkg::CTRL_FF_POS];
          s_nxt.rpc      = hwdata[snp_pkg::CTRL_RPC_POS];
          s_nxt.lines_sw = hwdata[snp_pkg::CTRL_LINES_LSB +: 2];
        end
        snp_pkg::REG_INTERVAL: s_nxt.interval = hwdata[15:0];
        snp_pkg::REG_SEP_CFG: begin
          s_nxt.sep_len = (hwdata[snp_pkg::SEP_LEN_LSB +: 3] > snp_pkg::SEP_MAX_LEN) ?
                          snp_pkg::SEP_MAX_LEN : hwdata[snp_pkg::SEP_LEN_LSB +: 3];
          s_nxt.sep_op  = (hwdata[snp_pkg::SEP_OP_LSB +: 2] > snp_pkg::SEP_MAX_OP) ?
                          snp_pkg::SEP_MAX_OP : hwdata[snp_pkg::SEP_OP_LSB +: 2];
        end
        snp_pkg::REG_SEP_BYTES: s_nxt.sep_bytes = hwdata;
        default: ;
      endcase
    end

    // Address phase capture; zero wait, always OKAY
    s_nxt.a_sel  = hsel & htrans[1] & hready;
    s_nxt.a_wr   = hwrite;
    s_nxt.a_addr = haddr[7:0];
    s_nxt.hready = 1'b1;
    s_nxt.hresp  = 1'b0;

    // 10 ms prescaler: restarts on each byte in fast-forward, free-running otherwise
    if (acc && s_r.ff) begin
      s_nxt.pre = '0;
    end else if (s_r.pre >= PW'(UNIT_CYC - 1)) begin
      s_nxt.pre = '0;
      tick      = 1'b1;
    end else begin
      s_nxt.pre = s_r.pre + 1'b1;
    end

    // Packet framer
    case (s_r.st)
      snp_pkg::ST_COLLECT: begin
        if (acc) begin
          s_nxt.mem[s_r.cnt] = ser_data;
          s_nxt.cnt          = s_r.cnt + 1'b1;
          s_nxt.units        = 16'h0000;
          if (s_r.tail_on) begin
            s_nxt.tail = s_r.tail - 1'b1;
            if (s_r.tail == 2'h1) begin
              s_nxt.tail_on = 1'b0;
              flush         = 1'b1;
            end
          end else if (s_r.sep_len != 3'h0) begin
            if (ser_data == snp_sep_byte(s_r.sep_bytes, s_r.match[1:0])) begin
              m = s_r.match + 3'h1;
            end else begin
              m = {2'b00, ser_data == snp_sep_byte(s_r.sep_bytes, 2'h0)};
            end
            if (m == s_r.sep_len) begin
              s_nxt.match = 3'h0;
              if (s_r.sep_op == 2'h0) begin
                flush = 1'b1;
              end else begin
                s_nxt.tail_on = 1'b1;
                s_nxt.tail    = s_r.sep_op;
              end
            end else begin
              s_nxt.match = m;
            end
          end
          if (s_r.cnt == CW'(DEPTH - 1) || s_r.interval == 16'h0000) begin
            flush = 1'b1;
          end
        end else if (s_r.cnt != '0) begin
          if (s_r.units >= s_r.interval) begin
            flush = 1'b1;
          end else if (tick) begin
            s_nxt.units = s_r.units + 16'h0001;
          end
        end
        if (flush) begin
          s_nxt.st   = s_r.ff ? snp_pkg::ST_DRAIN : snp_pkg::ST_HOLD;
          s_nxt.hold = '0;
        end
      end
      snp_pkg::ST_HOLD: begin
        if (s_r.hold >= HW'(snp_pkg::HOLDOFF_CYC - 1)) begin
          s_nxt.st = snp_pkg::ST_DRAIN;
        end else begin
          s_nxt.hold = s_r.hold + 1'b1;
        end
      end
      snp_pkg::ST_DRAIN: begin
        if (bf.ready) begin
          s_nxt.rd = s_r.rd + 1'b1;
          if (last) begin
            s_nxt.st      = snp_pkg::ST_COLLECT;
            s_nxt.cnt     = '0;
            s_nxt.rd      = '0;
            s_nxt.units   = 16'h0000;
            s_nxt.match   = 3'h0;
            s_nxt.tail_on = 1'b0;
          end
        end
      end
      default: s_nxt.st = snp_pkg::ST_COLLECT;
    endcase
    s_nxt.ser_ready = (s_nxt.st == snp_pkg::ST_COLLECT) && (s_nxt.cnt != CW'(DEPTH));

    // Handshake lines: with remote control on, report local changes and apply peer state; off, apply lines_sw
    s_nxt.rep_valid = 1'b0;
    s_nxt.seen      = local_lines;
    if (s_r.rpc && local_lines != s_r.seen) begin
      s_nxt.rep_valid = 1'b1;
      s_nxt.rep       = local_lines;
    end
    if (!s_r.rpc) begin
      s_nxt.applied = s_r.lines_sw;
    end else if (peer_lines_valid) begin
      s_nxt.applied = peer_lines;
    end

    // Read data, forwarding a write in the same cycle
    if (s_nxt.a_sel && !hwrite) begin
      s_nxt.hrdata = snp_read(s_nxt, haddr[7:0]);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r           <= '0;
      s_r.hready    <= 1'b1;
      s_r.interval  <= snp_pkg::RST_INTERVAL;
      s_r.sep_bytes <= snp_pkg::RST_SEP_BYTES;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer toward the network
  // ----------------------------------------------------------------
  // Drain word with its end-of-packet mark
  assign bf.valid = (s_r.st == snp_pkg::ST_DRAIN);
  assign bf.data  = {last, s_r.mem[s_r.rd]};

  snp_skid_buf #(
    .W (9)
  ) u_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_if     (bf.snk),
    .out_data  (net_word),
    .out_valid (net_valid),
    .out_ready (net_ready)
  );

  // Registered outputs
  assign net_data          = net_word[7:0];
  assign net_last          = net_word[8];
  assign hreadyout         = s_r.hready;
  assign hresp             = s_r.hresp;
  assign hrdata            = s_r.hrdata;
  assign ser_ready         = s_r.ser_ready;
  assign line_report_valid = s_r.rep_valid;
  assign line_report       = s_r.rep;
  assign applied_lines     = s_r.applied;

endmodule : snp_packetizer

/* hdl/snp_pkg.sv */
package snp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned FRAME_UNIT_MS  = 10;
  localparam int unsigned FRAME_UNIT_CYC = (FRAME_UNIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned HOLDOFF_NS     = 200;
  localparam int unsigned HOLDOFF_CYC    = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, low address bits only)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_INTERVAL  = 8'h04;
  localparam logic [7:0]  REG_SEP_CFG   = 8'h08;
  localparam logic [7:0]  REG_SEP_BYTES = 8'h0C;
  localparam logic [7:0]  REG_STATUS    = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_FF_POS     = 0;
  localparam int unsigned CTRL_RPC_POS    = 1;
  localparam int unsigned CTRL_LINES_LSB  = 4;
  localparam int unsigned SEP_LEN_LSB     = 0;
  localparam int unsigned SEP_OP_LSB      = 4;
  localparam int unsigned STAT_CNT_LSB    = 0;
  localparam int unsigned STAT_DRAIN_POS  = 8;
  localparam int unsigned STAT_HOLD_POS   = 9;
  localparam int unsigned STAT_LOCAL_LSB  = 12;
  localparam int unsigned STAT_PEER_LSB   = 14;
  localparam int unsigned STAT_MATCH_LSB  = 16;

  // ----------------------------------------------------------------
  // Limits and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  SEP_MAX_LEN     = 3'h4;
  localparam logic [1:0]  SEP_MAX_OP      = 2'h2;
  localparam logic [15:0] RST_INTERVAL    = 16'h0000;
  localparam logic [31:0] RST_SEP_BYTES   = 32'h0000_0000;

  // Packet framer states
  typedef enum logic [1:0] {
    ST_COLLECT,
    ST_HOLD,
    ST_DRAIN
  } snp_fsm_t;

endpackage : snp_pkg

/* hdl/snp_buf_if.sv */
`timescale 1ns/10ps
// Word path into the two-entry output buffer
interface snp_buf_if #(
  parameter int W = 9
) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : snp_buf_if

/* hdl/snp_skid_buf.sv */
`timescale 1ns/10ps
module snp_skid_buf #(
  parameter int W = 9
) (
  input  wire logic      sys_clk,
  input  wire logic      reset,
  snp_buf_if.snk         in_if,
  output logic [W-1:0]   out_data,
  output logic           out_valid,
  input  wire logic      out_ready
);

  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic         v0;
    logic         v1;
  } snp_buf_st_t;

  snp_buf_st_t s_r;
  snp_buf_st_t s_nxt;
  logic        push;
  logic        pop;

  // ----------------------------------------------------------------
  // Next state: head is e0, e1 shifts forward on a pop
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    push  = in_if.valid & ~s_r.v1;
    pop   = out_ready & s_r.v0;
    if (pop) begin
      s_nxt.e0 = s_r.e1;
      s_nxt.v0 = s_r.v1;
      s_nxt.v1 = 1'b0;
    end
    if (push) begin
      if (!s_nxt.v0) begin
        s_nxt.e0 = in_if.data;
        s_nxt.v0 = 1'b1;
      end else begin
        s_nxt.e1 = in_if.data;
        s_nxt.v1 = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ready drops only when both entries hold data
  assign in_if.ready = ~s_r.v1;
  assign out_data    = s_r.e0;
  assign out_valid   = s_r.v0;

endmodule : snp_skid_buf

/* dv/snp_props.sv */
`timescale 1ns/10ps
module snp_props (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        ser_ready,
  input wire logic [7:0]  net_data,
  input wire logic        net_last,
  input wire logic        net_valid,
  input wire logic        net_ready,
  input wire logic [1:0]  local_lines,
  input wire logic        line_report_valid,
  input wire logic [1:0]  line_report
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Bus answers: always OKAY, never stalls, read data held
  chk_resp_okay: assert property (!hresp)
    else $error("hresp not OKAY");
  chk_ready_stays: assert property (hreadyout |=> hreadyout)
    else $error("hreadyout dropped");
  chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("hrdata changed without a read");

  // Packet output held under stall; words of one packet follow without a gap
  chk_out_stable: assert property (
    net_valid && !net_ready |=> net_valid && $stable({net_data, net_last}))
    else $error("output word changed under stall");
  chk_packet_no_gap: assert property (net_valid && net_ready && !net_last |=> net_valid)
    else $error("gap inside a packet");

  // Line reports follow a real change of the local lines
  chk_line_value: assert property (
    line_report_valid |-> line_report == $past(local_lines)
      && $past(local_lines) != $past(local_lines, 2))
    else $error("line report wrong value");
  chk_line_quiet: assert property ($stable(local_lines) |=> !line_report_valid)
    else $error("line report without change");
  chk_report_hold: assert property (!line_report_valid |-> $stable(line_report))
    else $error("line report moved without pulse");
endmodule : snp_props

/* dv/snp_ser_host.sv */
`timescale 1ns/10ps
module snp_ser_host (
  input  wire logic sys_clk,
  input  wire logic ser_ready,
  output logic [7:0] ser_data,
  output logic      ser_valid
);
  // Idle at time zero
  initial begin
    ser_data = 8'h00;
    ser_valid = 1'h0;
  end

  // Present one byte and hold it until it is taken
  task automatic send(input logic [7:0] b);
    @(posedge sys_clk);
    ser_valid <= 1'h1;
    ser_data <= b;
    #1;
    while (ser_ready !== 1'h1) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    ser_valid <= 1'h0;
    ser_data <= ~b; // Released line shows no stale byte
  endtask : send
endmodule : snp_ser_host

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam int UC = 20;
  logic        sys_clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic        net_ready = 1'h0, peer_lines_valid = 1'h0;
  logic [1:0]  htrans = 2'h0, local_lines = 2'h0, peer_lines = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic        hreadyout, hresp, ser_ready, ser_valid, net_last, net_valid, line_report_valid;
  logic [7:0]  ser_data, net_data;
  logic [1:0]  line_report, applied_lines;
  logic [15:0] lfsr = 16'h188c;
  logic [8:0]  got[$], exp[$];
  logic [7:0]  s[7];
  int          error_cnt = 0, compares = 0, cyc = 0, first_t = -1, pulses = 0, t0;
  int          lat[2];

  // ----------------------------------------------------------------
  // Design, serial host and clock
  // ----------------------------------------------------------------
  snp_packetizer #(.UNIT_CYC(UC), .DEPTH(32)) dut_u (
    .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ser_data(ser_data),
    .ser_valid(ser_valid), .ser_ready(ser_ready), .net_data(net_data),
    .net_last(net_last), .net_valid(net_valid), .net_ready(net_ready),
    .local_lines(local_lines), .line_report_valid(line_report_valid),
    .line_report(line_report), .peer_lines_valid(peer_lines_valid),
    .peer_lines(peer_lines), .applied_lines(applied_lines));
  snp_ser_host host_u (.sys_clk(sys_clk), .ser_ready(ser_ready), .ser_data(ser_data),
    .ser_valid(ser_valid));
  // Free-running 40 MHz clock
  initial forever #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lf(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lf
  // Length of the first packet in separator case k
  function automatic int cut(input int k);
    return k < 3 ? 5 + k : 7;
  endfunction : cut
  task automatic results();
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  // One single AHB-Lite transfer, answer taken when hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    #1;
    while (hreadyout !== 1'h1) begin @(posedge sys_clk); #1; end
    @(posedge sys_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    #1;
    while (hreadyout !== 1'h1) begin @(posedge sys_clk); #1; end
    @(posedge sys_clk);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    check(n, e, rd);
  endtask : rdchk
  // Wait for the expected words, then compare word by word
  task automatic pkts(input string n);
    int i;
    i = 0;
    while (got.size() < exp.size() && i < 4000) begin @(posedge sys_clk); i++; end
    repeat (30) @(posedge sys_clk);
    check({n, " count"}, 32'(exp.size()), 32'(got.size()));
    foreach (exp[k]) if (k < got.size()) check(n, 32'(exp[k]), 32'(got[k]));
    got.delete();
    exp.delete();
  endtask : pkts
  // Drive peer and local lines, then compare applied lines and reports
  task automatic lines(input logic [31:0] c, input logic [1:0] p, input logic [1:0] l,
                       input logic [1:0] ea, input int ep, input logic [1:0] er);
    bus(1'h1, snp_pkg::REG_CTRL, c);
    @(posedge sys_clk);
    peer_lines <= p;
    peer_lines_valid <= 1'h1;
    local_lines <= l;
    @(posedge sys_clk);
    peer_lines_valid <= 1'h0;
    repeat (3) @(posedge sys_clk);
    check("applied lines", 32'(ea), 32'(applied_lines));
    check("line reports", 32'(ep), 32'(pulses));
    check("line report", 32'(er), 32'(line_report));
  endtask : lines

  // Network sink with random stalls, cycle count and hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    lfsr <= lf(lfsr);
    net_ready <= lfsr[0] | lfsr[1];
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // Words and pulses taken where they are settled
  always @(negedge sys_clk) begin
    if (net_valid === 1'h1 && first_t < 0) first_t = cyc;
    if (net_valid === 1'h1 && net_ready === 1'h1) got.push_back({net_last, net_data});
    if (line_report_valid === 1'h1) pulses++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    rdchk("interval", snp_pkg::REG_INTERVAL, 32'h0000_0000);
    rdchk("sep bytes", snp_pkg::REG_SEP_BYTES, 32'h0000_0000);
    bus(1'h1, snp_pkg::REG_SEP_CFG, 32'h0000_0037);
    rdchk("sep cfg", snp_pkg::REG_SEP_CFG, 32'h0000_0024);
    bus(1'h1, 8'h20, 32'h0000_ffff);
    rdchk("unmapped", 8'h20, 32'h0000_0000);
    bus(1'h1, snp_pkg::REG_SEP_CFG, 32'h0000_0000);
    for (int f = 0; f < 2; f++) begin
      bus(1'h1, snp_pkg::REG_CTRL, 32'(f));
      first_t = -1;
      for (int i = 0; i < 2; i++) begin
        s[i] = lfsr[15:8];
        host_u.send(s[i]);
        if (i == 0) t0 = cyc;
        exp.push_back({1'h1, s[i]});
      end
      pkts("byte packet");
      lat[f] = first_t - t0;
    end
    check("holdoff", 32'h0000_0001,
          32'(lat[0] - lat[1] >= int'(snp_pkg::HOLDOFF_CYC)));
    bus(1'h1, snp_pkg::REG_INTERVAL, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      s[i] = lfsr[15:8];
      host_u.send(s[i]);
      exp.push_back({i == 3, s[i]});
    end
    t0 = cyc;
    first_t = -1;
    pkts("idle packet");
    check("idle gap", 32'h0000_0001,
          32'(first_t - t0 >= 2 * UC && first_t - t0 <= 2 * UC + 12));
    bus(1'h1, snp_pkg::REG_CTRL, 32'h0000_0000);
    bus(1'h1, snp_pkg::REG_INTERVAL, 32'h0000_0008);
    bus(1'h1, snp_pkg::REG_SEP_BYTES, 32'h0000_55aa);
    for (int k = 0; k < 4; k++) begin
      bus(1'h1, snp_pkg::REG_SEP_CFG, k < 3 ? 32'(k * 16 + 2) : 32'h0000_0000);
      s = '{8'haa, 8'h01, 8'haa, 8'haa, 8'h55, lfsr[7:0] & 8'h7f, lfsr[15:8] & 8'h7f};
      for (int i = 0; i < 7; i++) begin
        host_u.send(s[i]);
        exp.push_back({i == 6 || i == cut(k) - 1, s[i]});
      end
      pkts("sep packet");
    end
    lines(32'h0000_0020, 2'h1, 2'h3, 2'h2, 0, 2'h0);
    lines(32'h0000_0002, 2'h3, 2'h1, 2'h3, 1, 2'h1);
    // Status shows sampled local lines and applied peer lines, store empty
    rdchk("status", snp_pkg::REG_STATUS, (32'h0000_0001 << snp_pkg::STAT_LOCAL_LSB) |
          (32'h0000_0003 << snp_pkg::STAT_PEER_LSB));
    results();
  end
endmodule : tb_top

bind snp_packetizer snp_props chk_u (
  .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ser_ready(ser_ready), .net_data(net_data), .net_last(net_last), .net_valid(net_valid),
  .net_ready(net_ready), .local_lines(local_lines), .line_report_valid(line_report_valid),
  .line_report(line_report));
